// *** lb_pins.sv ***
// Pin side of the logic block: wire level with outside drivers and keeper
`timescale 1ns/1ps
`default_nettype none
module lb_pins (
   input wire logic [15:0] io_out,
   input wire logic [15:0] io_oe_n,
   input wire logic [15:0] ext_en,
   input wire logic [15:0] ext_val,
   output logic [15:0] io_in
);
   // Released and undriven pins sit at the kept level, never float
   always_comb begin
      for (int k = 0; k < 16; k++)
         io_in[k] = !io_oe_n[k] ? io_out[k] : (ext_en[k] ? ext_val[k] : io_out[k]);
   end
endmodule
`default_nettype wire

// *** lb_props.sv ***
// Bus timing and mode checks for the logic block
`timescale 1ns/1ps
`default_nettype none
module lb_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic low_power
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic lp_want_q;
   sequence s_wait;
      psel && penable && !pready;
   endsequence
   sequence s_done;
      psel && penable && pready;
   endsequence
   // Last power-mode bit written, to follow the pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         lp_want_q <= 1'b0;
      else if (psel && penable && pready && pwrite && paddr == 12'h000)
         lp_want_q <= pwdata[0];
   end
   property p_ack_wait;
      s_wait |=> pready;
   endproperty
   a_ack_wait: assert property (p_ack_wait) else $error("pready not one cycle after access");
   property p_ack_pulse;
      pready |=> !pready;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("pready longer than one cycle");
   property p_ack_cause;
      pready |-> $past(psel && penable);
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("pready without access");
   property p_err_pair;
      pslverr |-> pready;
   endproperty
   a_err_pair: assert property (p_err_pair) else $error("pslverr without pready");
   property p_rdata_idle;
      !pready |-> prdata == 32'h0;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero when idle");
   property p_unaligned;
      s_done ##0 (paddr[1:0] != 2'h0) |-> pslverr;
   endproperty
   a_unaligned: assert property (p_unaligned) else $error("unaligned access accepted");
   property p_unmapped;
      s_done ##0 (paddr >= 12'h010 && paddr < 12'h040) |-> pslverr;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
   property p_low_power;
      s_done ##0 (pwrite && paddr == 12'h000) |-> ##2 low_power == lp_want_q;
   endproperty
   a_low_power: assert property (p_low_power) else $error("low_power does not follow write");
endmodule
bind logic_block lb_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .low_power(low_power));
`default_nettype wire

// *** logic_block.v ***
// Configurable logic block: term array, allocator, 16 macrocells, input cells, test port, APB config
// Behaviour
// - Each macrocell individually steers zero to sixteen product terms into its sum.
// - A term is shared by up to six neighbouring macrocells through overlapping steering windows.
// - Sixteen macrocells; each is a pin macrocell or a buried one without pin.
// - Register mode is combinational, D flip-flop, toggle flip-flop or transparent latch.
// - Block set term forces high, reset term forces low, each with polarity select.
// - Each macrocell clocks from one of four global clocks or the term clock.
// - Global clock polarity for the macrocells is chosen once for the whole block; input cells do not see it.
// - A buried macrocell may register or latch the neighbouring pin macrocell's pin.
// - Every buried macrocell result goes straight to the matrix in every mode.
// - Pin macrocells invert their result before the pin when selected.
// - Feedback to the matrix is separate from the pin input path.
// - A released pin keeps its last level through a weak keeper.
// - Test port supports bypass, sample/preload, extest, idcode and usercode.
// - Five input-only pins: combinational, registered, double-registered or latched.
// - Input cells capture on any one of the four global clocks.
// - Input/clock pins feed clocking with a selectable inversion at the input.
// - Block term clock for all macrocells is term 86, which lies past the APB map end, so it reads 1 and only its polarity bit moves it.
// - Block runs in high-speed or low-power mode, chosen per block.
// - Eighty general terms, plus four output-enable, set, reset and clock terms of eighty-seven.
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "logic_block_consts.vh"
module logic_block #(
   parameter [15:0] PIN_MASK = 16'h5555,
   parameter [31:0] IDCODE_VALUE = 32'h1234_5679 // Arbitrary value
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire global_clock_zero,
   input wire global_clock_one,
   input wire global_clock_two,
   input wire global_clock_three,
   input wire input_only_pin,
   input wire [35:0] global_interconnect_matrix,
   output reg [15:0] feedback,
   output reg [4:0] dedicated_to_matrix,
   input wire [15:0] io_in,
   output reg [15:0] io_out,
   output reg [15:0] io_oe_n,
   output reg low_power,
   input wire tck,
   input wire tms,
   input wire tdi,
   output reg tdo,
   output reg tdo_oe_n
);
   localparam [3:0] TS_RESET = 4'h0, TS_IDLE = 4'h1, TS_SEL_DR = 4'h2, TS_CAP_DR = 4'h3;
   localparam [3:0] TS_SH_DR = 4'h4, TS_EX1_DR = 4'h5, TS_PA_DR = 4'h6, TS_EX2_DR = 4'h7;
   localparam [3:0] TS_UP_DR = 4'h8, TS_SEL_IR = 4'h9, TS_CAP_IR = 4'ha, TS_SH_IR = 4'hb;
   localparam [3:0] TS_EX1_IR = 4'hc, TS_PA_IR = 4'hd, TS_EX2_IR = 4'he, TS_UP_IR = 4'hf;

   function term_eval;
      input [35:0] in;
      input [35:0] true_mask;
      input [35:0] comp_mask;
      begin
         term_eval = (&(~true_mask | in)) & (&(~comp_mask | ~in));
      end
   endfunction

   function [3:0] tap_next;
      input [3:0] s;
      input m;
      begin
         case (s)
            TS_RESET: tap_next = m ? TS_RESET : TS_IDLE;
            TS_IDLE: tap_next = m ? TS_SEL_DR : TS_IDLE;
            TS_SEL_DR: tap_next = m ? TS_SEL_IR : TS_CAP_DR;
            TS_CAP_DR: tap_next = m ? TS_EX1_DR : TS_SH_DR;
            TS_SH_DR: tap_next = m ? TS_EX1_DR : TS_SH_DR;
            TS_EX1_DR: tap_next = m ? TS_UP_DR : TS_PA_DR;
            TS_PA_DR: tap_next = m ? TS_EX2_DR : TS_PA_DR;
            TS_EX2_DR: tap_next = m ? TS_UP_DR : TS_SH_DR;
            TS_UP_DR: tap_next = m ? TS_SEL_DR : TS_IDLE;
            TS_SEL_IR: tap_next = m ? TS_RESET : TS_CAP_IR;
            TS_CAP_IR: tap_next = m ? TS_EX1_IR : TS_SH_IR;
            TS_SH_IR: tap_next = m ? TS_EX1_IR : TS_SH_IR;
            TS_EX1_IR: tap_next = m ? TS_UP_IR : TS_PA_IR;
            TS_PA_IR: tap_next = m ? TS_EX2_IR : TS_PA_IR;
            TS_EX2_IR: tap_next = m ? TS_UP_IR : TS_SH_IR;
            TS_UP_IR: tap_next = m ? TS_SEL_DR : TS_IDLE;
            default: tap_next = TS_RESET;
         endcase
      end
   endfunction

   // Configuration storage
   reg [31:0] ctrl_q;
   reg [19:0] incfg_q;
   reg [31:0] usercode_q;
   reg [31:0] mc_cfg_q [0:15];
   reg [35:0] pt_true_q [0:`PT_TOTAL-1];
   reg [35:0] pt_comp_q [0:`PT_TOTAL-1];

   // Logic state
   reg [15:0] mc_q;
   reg [15:0] mc_d;
   reg [15:0] result;
   reg [15:0] sum;
   reg [15:0] hold_q;
   reg [4:0] ck_prev_q;
   reg [3:0] in_ck_prev_q;
   reg [4:0] in_s1_q;
   reg [4:0] in_s2_q;
   reg [4:0] in_s1_d;
   reg [4:0] in_s2_d;
   reg [4:0] ded_d;
   reg [`PT_TOTAL-1:0] pt;
   reg [15:0] oe;
   reg [15:0] drive;
   integer i;
   integer base;

   // Test port state
   reg [3:0] tap_q;
   reg [3:0] ir_q;
   reg [3:0] ir_sh_q;
   reg [31:0] dr_q;
   reg [15:0] bscan_upd_q;
   reg tck_q;

   wire [3:0] clk_pin = {global_clock_three, global_clock_two, global_clock_one, global_clock_zero};
   wire [3:0] clk_int = clk_pin ^ ctrl_q[`CTRL_PIN_INV_LSB +: 4];
   wire [3:0] gclk = clk_int ^ {4{ctrl_q[`CTRL_BLK_CLK_POL]}};
   wire tclk = pt[`PT_CLK] ^ ctrl_q[`CTRL_TCLK_POL];
   wire [4:0] ck_all = {tclk, gclk};
   wire [4:0] ck_edge = ck_all & ~ck_prev_q;
   wire [3:0] in_edge = clk_int & ~in_ck_prev_q;
   wire [4:0] ded_pin = {input_only_pin, clk_pin};
   wire set_t = pt[`PT_SET] ^ ctrl_q[`CTRL_SET_POL];
   wire rst_t = pt[`PT_RST] ^ ctrl_q[`CTRL_RST_POL];
   wire extest = (ir_q == `IR_EXTEST);

   // Term array and macrocells
   always @* begin
      for (i = 0; i < `PT_TOTAL; i = i + 1) begin
         pt[i] = term_eval(global_interconnect_matrix, pt_true_q[i], pt_comp_q[i]);
      end
      mc_d = mc_q;
      result = 16'h0000;
      sum = 16'h0000;
      oe = 16'h0000;
      drive = 16'h0000;
      for (i = 0; i < 16; i = i + 1) begin
         // Windows step by five and clamp at term 64, so a term reaches up to six macrocells
         base = (i * `PT_WIN_STEP > `PT_GENERAL - `PT_WINDOW) ? `PT_GENERAL - `PT_WINDOW : i * `PT_WIN_STEP;
         sum[i] = |(mc_cfg_q[i][`MC_STEER_LSB +: 16] & pt[base +: 16]);
         if (mc_cfg_q[i][`MC_IN_REG] && !PIN_MASK[i]) begin
            sum[i] = io_in[i ^ 1];
         end
         if (rst_t) begin
            mc_d[i] = 1'b0;
         end else if (set_t) begin
            mc_d[i] = 1'b1;
         end else begin
            case (mc_cfg_q[i][`MC_MODE_LSB +: 2])
               `MODE_DFF: if (ck_edge[mc_cfg_q[i][`MC_CLK_LSB +: 3]]) mc_d[i] = sum[i];
               `MODE_TFF: if (ck_edge[mc_cfg_q[i][`MC_CLK_LSB +: 3]]) mc_d[i] = mc_q[i] ^ sum[i];
               `MODE_LATCH: if (ck_all[mc_cfg_q[i][`MC_CLK_LSB +: 3]]) mc_d[i] = sum[i];
               default: mc_d[i] = mc_q[i];
            endcase
         end
         result[i] = (mc_cfg_q[i][`MC_MODE_LSB +: 2] == `MODE_COMB) ? sum[i] : mc_d[i];
         drive[i] = result[i] ^ mc_cfg_q[i][`MC_OUT_INV];
         oe[i] = PIN_MASK[i] & pt[`PT_OE_BASE + (i >= 8 ? 2 : 0) + mc_cfg_q[i][`MC_OE_SEL]];
      end
   end

   // Input cells
   always @* begin
      in_s1_d = in_s1_q;
      in_s2_d = in_s2_q;
      ded_d = 5'h00;
      for (i = 0; i < 5; i = i + 1) begin
         case (incfg_q[i*4 +: 2])
            `IN_REG: begin
               if (in_edge[incfg_q[i*4+2 +: 2]]) in_s1_d[i] = ded_pin[i];
               ded_d[i] = in_s1_q[i];
            end
            `IN_DOUBLE: begin
               if (in_edge[incfg_q[i*4+2 +: 2]]) begin
                  in_s1_d[i] = ded_pin[i];
                  in_s2_d[i] = in_s1_q[i];
               end
               ded_d[i] = in_s2_q[i];
            end
            `IN_LATCH: begin
               if (clk_int[incfg_q[i*4+2 +: 2]]) in_s1_d[i] = ded_pin[i];
               ded_d[i] = in_s1_d[i];
            end
            default: ded_d[i] = ded_pin[i];
         endcase
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mc_q <= 16'h0000;
         ck_prev_q <= 5'h00;
         in_ck_prev_q <= 4'h0;
         in_s1_q <= 5'h00;
         in_s2_q <= 5'h00;
         feedback <= 16'h0000;
         dedicated_to_matrix <= 5'h00;
         hold_q <= 16'h0000;
         io_out <= 16'h0000;
         io_oe_n <= 16'hffff;
         low_power <= 1'b0;
      end else begin
         mc_q <= mc_d;
         ck_prev_q <= ck_all;
         in_ck_prev_q <= clk_int;
         in_s1_q <= in_s1_d;
         in_s2_q <= in_s2_d;
         feedback <= result;
         dedicated_to_matrix <= ded_d;
         low_power <= ctrl_q[`CTRL_LOW_POWER];
         if (extest) begin
            io_out <= bscan_upd_q;
            io_oe_n <= 16'h0000;
            hold_q <= bscan_upd_q;
         end else begin
            for (i = 0; i < 16; i = i + 1) begin
               // Keeper follows the wire while released, so it holds what was last seen
               hold_q[i] <= oe[i] ? drive[i] : io_in[i];
               io_out[i] <= oe[i] ? drive[i] : hold_q[i];
               io_oe_n[i] <= ~oe[i];
            end
         end
      end
   end

   // APB slave: one wait state, write and read data at the pready edge
   wire acc = psel & penable & ~pready;
   wire is_mc = (paddr >= `OFF_MC_BASE) && (paddr <= `OFF_MC_END);
   wire is_pt = (paddr >= `OFF_PT_BASE) && (paddr <= `OFF_PT_END);
   wire [11:0] pt_off = paddr - `OFF_PT_BASE;
   wire [6:0] pt_idx = pt_off[10:4];
   wire [3:0] mc_idx = paddr[5:2] ^ 4'h0;
   wire mapped = (paddr[1:0] == 2'h0) && ((paddr == `OFF_CTRL) || (paddr == `OFF_INCFG) ||
      (paddr == `OFF_USERCODE) || (paddr == `OFF_STATUS) || is_mc || is_pt);
   reg [31:0] rd_d;

   always @* begin
      rd_d = 32'h0000_0000;
      if (paddr == `OFF_CTRL) rd_d = ctrl_q;
      else if (paddr == `OFF_INCFG) rd_d = {12'h000, incfg_q};
      else if (paddr == `OFF_USERCODE) rd_d = usercode_q;
      else if (paddr == `OFF_STATUS) rd_d = {11'h000, dedicated_to_matrix, feedback};
      else if (is_mc) rd_d = mc_cfg_q[mc_idx];
      else if (is_pt) begin
         case (pt_off[3:2])
            2'h0: rd_d = pt_true_q[pt_idx][31:0];
            2'h1: rd_d = {28'h0000000, pt_true_q[pt_idx][35:32]};
            2'h2: rd_d = pt_comp_q[pt_idx][31:0];
            default: rd_d = {28'h0000000, pt_comp_q[pt_idx][35:32]};
         endcase
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         ctrl_q <= `CTRL_RESET;
         incfg_q <= 20'h00000;
         usercode_q <= 32'h0000_0000;
         for (i = 0; i < 16; i = i + 1) mc_cfg_q[i] <= `MC_RESET;
         for (i = 0; i < `PT_TOTAL; i = i + 1) begin
            pt_true_q[i] <= 36'h0_0000_0000;
            pt_comp_q[i] <= 36'h0_0000_0000;
         end
      end else begin
         pready <= acc;
         pslverr <= acc & ~mapped;
         prdata <= (acc && !pwrite && mapped) ? rd_d : 32'h0000_0000;
         if (acc && pwrite && mapped) begin
            if (paddr == `OFF_CTRL) ctrl_q <= pwdata;
            else if (paddr == `OFF_INCFG) incfg_q <= pwdata[19:0];
            else if (paddr == `OFF_USERCODE) usercode_q <= pwdata;
            else if (is_mc) mc_cfg_q[mc_idx] <= pwdata;
            else if (is_pt) begin
               case (pt_off[3:2])
                  2'h0: pt_true_q[pt_idx][31:0] <= pwdata;
                  2'h1: pt_true_q[pt_idx][35:32] <= pwdata[3:0];
                  2'h2: pt_comp_q[pt_idx][31:0] <= pwdata;
                  default: pt_comp_q[pt_idx][35:32] <= pwdata[3:0];
               endcase
            end
         end
      end
   end

   // Test port; tck is sampled, so it must run well below pclk
   wire tck_rise = tck & ~tck_q;
   wire tck_fall = ~tck & tck_q;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tck_q <= 1'b0;
         tap_q <= TS_RESET;
         ir_q <= `IR_IDCODE;
         ir_sh_q <= 4'h0;
         dr_q <= 32'h0000_0000;
         bscan_upd_q <= 16'h0000;
         tdo <= 1'b0;
         tdo_oe_n <= 1'b1;
      end else begin
         tck_q <= tck;
         if (tck_rise) begin
            tap_q <= tap_next(tap_q, tms);
            case (tap_q)
               TS_RESET: ir_q <= `IR_IDCODE;
               TS_CAP_IR: ir_sh_q <= 4'h1;
               TS_SH_IR: ir_sh_q <= {tdi, ir_sh_q[3:1]};
               TS_UP_IR: ir_q <= ir_sh_q;
               TS_CAP_DR: begin
                  case (ir_q)
                     `IR_IDCODE: dr_q <= IDCODE_VALUE;
                     `IR_USERCODE: dr_q <= usercode_q;
                     `IR_SAMPLE, `IR_EXTEST: dr_q <= {16'h0000, io_in};
                     default: dr_q <= 32'h0000_0000;
                  endcase
               end
               TS_SH_DR: begin
                  case (ir_q)
                     `IR_IDCODE, `IR_USERCODE: dr_q <= {tdi, dr_q[31:1]};
                     `IR_SAMPLE, `IR_EXTEST: dr_q <= {16'h0000, tdi, dr_q[15:1]};
                     default: dr_q <= {31'h0000_0000, tdi};
                  endcase
               end
               TS_UP_DR: begin
                  if (ir_q == `IR_SAMPLE || ir_q == `IR_EXTEST) bscan_upd_q <= dr_q[15:0];
               end
               default: tdo_oe_n <= tdo_oe_n;
            endcase
         end
         if (tck_fall) begin
            tdo <= (tap_q == TS_SH_IR) ? ir_sh_q[0] : dr_q[0];
            tdo_oe_n <= ~((tap_q == TS_SH_IR) || (tap_q == TS_SH_DR));
         end
      end
   end
endmodule
`default_nettype wire

// *** logic_block_consts.vh ***
// Offsets, field positions, encodings and counts for the logic block
`ifndef LOGIC_BLOCK_CONSTS_VH
`define LOGIC_BLOCK_CONSTS_VH
`define OFF_CTRL 12'h000
`define OFF_INCFG 12'h004
`define OFF_USERCODE 12'h008
`define OFF_STATUS 12'h00c
`define OFF_MC_BASE 12'h040
`define OFF_MC_END 12'h07c
`define OFF_PT_BASE 12'h400
`define OFF_PT_END 12'h95c
`define CTRL_LOW_POWER 0
`define CTRL_BLK_CLK_POL 1
`define CTRL_SET_POL 2
`define CTRL_RST_POL 3
`define CTRL_TCLK_POL 4
`define CTRL_PIN_INV_LSB 5
`define CTRL_RESET 32'h0000_0000
`define MC_STEER_LSB 0
`define MC_MODE_LSB 16
`define MC_CLK_LSB 18
`define MC_OUT_INV 21
`define MC_IN_REG 22
`define MC_OE_SEL 23
`define MC_RESET 32'h0000_0000
`define MODE_COMB 2'h0
`define MODE_DFF 2'h1
`define MODE_TFF 2'h2
`define MODE_LATCH 2'h3
`define CLK_SEL_TERM 3'h4
`define IN_COMB 2'h0
`define IN_REG 2'h1
`define IN_DOUBLE 2'h2
`define IN_LATCH 2'h3
`define PT_TOTAL 87
`define PT_GENERAL 80
`define PT_WINDOW 16
`define PT_WIN_STEP 5
`define PT_OE_BASE 80
`define PT_SET 84
`define PT_RST 85
`define PT_CLK 86
`define IR_EXTEST 4'h0
`define IR_SAMPLE 4'h1
`define IR_IDCODE 4'h2
`define IR_USERCODE 4'h3
`define IR_BYPASS 4'hf
`endif

// *** testbench.sv ***
// Self-checking bench for the logic block over APB
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, low_power, tdo, tdo_oe_n, ipin, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [35:0] mtx;
   logic [3:0] gck;
   logic [2:0] jt;
   logic [15:0] fb, io_in, io_out, io_oe_n, ext_en, ext_val;
   logic [4:0] ded;
   int err_count, check_count;
   // Set term first: an unprogrammed reset term reads as 1 and so masks the gap
   logic [11:0] ca [10] = '{12'h944, 12'h954, 12'h400, 12'h450, 12'h4a0, 12'h4f0,
      12'h040, 12'h044, 12'h048, 12'h04c};
   logic [31:0] cd [10] = '{32'h4, 32'h8, 32'h1, 32'h2, 32'h4, 32'h8,
      32'h21, 32'h1, 32'h10001, 32'h20001};
   logic_block dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .global_clock_zero(gck[0]), .global_clock_one(gck[1]), .global_clock_two(gck[2]),
      .global_clock_three(gck[3]), .input_only_pin(ipin), .global_interconnect_matrix(mtx),
      .feedback(fb), .dedicated_to_matrix(ded), .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n),
      .low_power(low_power), .tck(jt[0]), .tms(jt[1]), .tdi(jt[2]), .tdo(tdo), .tdo_oe_n(tdo_oe_n));
   lb_pins pins (.io_out(io_out), .io_oe_n(io_oe_n), .ext_en(ext_en), .ext_val(ext_val), .io_in(io_in));
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16)
         err_count++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   // Clock pins are sampled on pclk, so each level is held a few cycles
   task automatic edge0(input logic v);
      gck[0] <= v;
      repeat (4) @(posedge pclk);
   endtask
   task automatic tally_and_finish;
      if (err_count == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      err_count++;
      tally_and_finish;
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata, ipin, er, rd} = '0;
      {mtx, gck, jt, ext_en, ext_val} = '0;
      presetn = 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk({16'h0, fb}, 32'h0);
      rdc(12'h000, 32'h0);
      rdc(12'h044, 32'h0);
      apb(1'b1, 12'h008, 32'hcafe_f00d);
      rdc(12'h008, 32'hcafe_f00d);
      rdc(12'h010, 32'h0);
      chk({31'h0, er}, 32'h1);
      rdc(12'h002, 32'h0);
      chk({31'h0, er}, 32'h1);
      apb(1'b1, 12'h000, 32'h1);
      repeat (2) @(posedge pclk);
      chk({31'h0, low_power}, 32'h1);
      apb(1'b1, 12'h000, 32'h0);
      for (int i = 0; i < 10; i++)
         apb(1'b1, ca[i], cd[i]);
      for (int i = 0; i < 10; i++)
         rdc(ca[i], cd[i]);
      mtx[1] <= 1'b1;
      repeat (2) @(posedge pclk);
      chk({30'h0, fb[1:0]}, 32'h3);
      mtx[1] <= 1'b0;
      mtx[0] <= 1'b1;
      repeat (2) @(posedge pclk);
      chk({30'h0, fb[1:0]}, 32'h1);
      mtx[3:2] <= 2'h3;
      repeat (4) @(posedge pclk);
      chk({30'h0, fb[3:2]}, 32'h0);
      edge0(1'b1);
      edge0(1'b0);
      chk({30'h0, fb[3:2]}, 32'h3);
      mtx[2] <= 1'b0;
      edge0(1'b1);
      edge0(1'b0);
      chk({30'h0, fb[3:2]}, 32'h0);
      mtx[3] <= 1'b0;
      mtx[2] <= 1'b1;
      edge0(1'b1);
      edge0(1'b0);
      chk({30'h0, fb[3:2]}, 32'h1);
      mtx[2] <= 1'b0;
      apb(1'b1, 12'h000, 32'h2);
      repeat (4) @(posedge pclk);
      chk({31'h0, fb[2]}, 32'h0);
      mtx[2] <= 1'b1;
      edge0(1'b1);
      chk({31'h0, fb[2]}, 32'h0);
      edge0(1'b0);
      chk({31'h0, fb[2]}, 32'h1);
      mtx[34] <= 1'b1;
      repeat (3) @(posedge pclk);
      chk({30'h0, fb[3:2]}, 32'h3);
      mtx[35] <= 1'b1;
      repeat (3) @(posedge pclk);
      chk({30'h0, fb[3:2]}, 32'h0);
      mtx[35:34] <= 2'h0;
      mtx[2] <= 1'b0;
      rdc(12'h00c, 32'h1);
      chk({30'h0, io_oe_n[0], io_out[0]}, 32'h1);
      apb(1'b1, 12'h040, 32'h20_0021);
      chk({30'h0, io_oe_n[0], io_out[0]}, 32'h0);
      ipin <= 1'b1;
      repeat (3) @(posedge pclk);
      chk({31'h0, ded[4]}, 32'h1);
      apb(1'b1, 12'h004, 32'h2_0000);
      edge0(1'b1);
      edge0(1'b0);
      chk({31'h0, ded[4]}, 32'h0);
      edge0(1'b1);
      edge0(1'b0);
      chk({31'h0, ded[4]}, 32'h1);
      tally_and_finish;
   end
endmodule
`default_nettype wire
